// ===== sim/sat_codec.sv
// Far-side serial audio master: sends one frame (left and right words) and one lead-out bit
module sat_codec
  import sat_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request
  input wire logic start,
  input wire logic [31:0] left,
  input wire logic [31:0] right,
  // Link
  output logic bck,
  output logic ws,
  output logic sd,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] step;
  logic [6:0] bidx;
  logic sd_last;
  ////////////////////////////////////////////////////////////////////////////
  // Burst counter, four aclk per bit; the clock idles low between bursts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      busy <= 1'b0;
    else if (start && !busy)
      busy <= 1'b1;
    else if (step == 9'h103)
      busy <= 1'b0;
    step <= busy ? step + 9'h1 : 9'h0;
    if (busy)
      sd_last <= sd;
  end
  // Data changes while bck is low, MSB first
  assign bidx = step[8:2];
  assign bck = busy & step[1];
  assign ws = busy & bidx[5];
  // Released data line shows the inverse, never a stale copy
  assign sd = busy ? (bidx[5] ? right[~bidx[4:0]] : left[~bidx[4:0]]) : ~sd_last;
endmodule

// ===== sim/tb_top.sv
`include "sat_map.svh"
module tb_top
  import sat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, dtx_data = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic dtx_valid = 1'b0, drx_ready = 1'b0, cstart = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dtx_ready, drx_valid, cbusy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, drx_data, sh;
  logic [31:0] cap [0:3];
  logic tbck, tbck_oe_n, tws, tsd, rbck, rbck_oe_n, cbck, cws, csd, pb, pw, b0;
  int fails = 0, samples_checked = 0, frames = 0, n, k;
  always #2.5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  sat_core sat_core_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .dma_tx_valid(dtx_valid), .dma_tx_data(dtx_data),
    .dma_tx_ready(dtx_ready), .dma_rx_valid(drx_valid), .dma_rx_data(drx_data),
    .dma_rx_ready(drx_ready), .tx_bck_out(tbck), .tx_bck_oe_n(tbck_oe_n), .tx_ws_out(tws),
    .tx_sd_out(tsd), .rx_bck_in(cbck), .rx_bck_out(rbck), .rx_bck_oe_n(rbck_oe_n),
    .rx_ws_in(cws), .rx_sd_in(csd));
  sat_codec sat_codec_i (.aclk(aclk), .aresetn(aresetn), .start(cstart),
    .left(32'h9a3c_5555), .right(32'h61e7_aaaa), .bck(cbck), .ws(cws), .sd(csd),
    .busy(cbusy));
  ////////////////////////////////////////////////////////////////////////////
  // Left slot of the first four transmit frames, caught on rising bit clock
  always @(posedge aclk)
  begin
    pb <= tbck;
    pw <= tws;
    if (tbck && !pb && !tws)
      sh <= {sh[30:0], tsd};
    if (tws && !pw && frames < 4)
    begin
      cap[frames] <= sh;
      frames <= frames + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int cnt, input int lim);
    if (cnt >= lim)
    begin
      fails++;
      wrap_up();
    end
  endtask
  // Address and data offered together; bready held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (!ad && awready)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready)
      begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    tmo(n, 200);
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    rready <= 1'b0;
    tmo(n, 200);
    chk({30'h0, rresp}, {30'h0, er});
    chk(rdata, ed);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`SAT_A_FCFG, 32'h0000_1000, 2'h0);
    rd(`SAT_A_CTRL, 32'h0, 2'h0);
    rd(8'h1c, 32'h0, 2'h2);
    wr(8'h20, 32'h1, 2'h2);
    wr(`SAT_A_CTRL, 32'h0abc_0000, 2'h0);
    rd(`SAT_A_CTRL, 32'h0abc_0000, 2'h0);
    wr(`SAT_A_CHAN, 32'h14, 2'h0);
    rd(`SAT_A_CHAN, 32'h14, 2'h0);
    // Every valid packing code in both directions
    for (k = 0; k < 6; k++)
    begin
      wr(`SAT_A_FCFG, 32'h1000 | (32'(k) << 13) | (32'(k % 4) << 16), 2'h0);
      rd(`SAT_A_FCFG, 32'h1000 | (32'(k) << 13) | (32'(k % 4) << 16), 2'h0);
    end
    wr(`SAT_A_CTRL, 32'h0, 2'h0);
    wr(`SAT_A_CHAN, 32'h0, 2'h0);
    wr(`SAT_A_FCFG, 32'h1000, 2'h0);
    // DMA path fills; software access is shut out meanwhile
    dtx_data <= 32'h1357_9bdf;
    dtx_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end while (!dtx_ready && n < 50);
    dtx_valid <= 1'b0;
    tmo(n, 50);
    rd(`SAT_A_STAT, 32'h1, 2'h0);
    wr(`SAT_A_TXDATA, 32'hffff_ffff, 2'h0);
    rd(`SAT_A_STAT, 32'h1, 2'h0);
    rd(`SAT_A_RXDATA, 32'h0, 2'h0);
    wr(`SAT_A_CTRL, 32'h4, 2'h0);
    rd(`SAT_A_STAT, 32'h0, 2'h0);
    wr(`SAT_A_CTRL, 32'h0, 2'h0);
    // Master transmit: zero frame, the word, then the same word again
    wr(`SAT_A_FCFG, 32'h0, 2'h0);
    wr(`SAT_A_TXDATA, 32'ha5c3_1234, 2'h0);
    rd(`SAT_A_STAT, 32'h1, 2'h0);
    wr(`SAT_A_CTRL, 32'h100, 2'h0);
    @(posedge aclk);
    chk({31'h0, tbck_oe_n}, 32'h0);
    n = 0;
    while (frames < 3 && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    tmo(n, 3000);
    chk(cap[0], 32'h0);
    chk({16'h0, cap[1][31:16]}, 32'ha5c3);
    chk({16'h0, cap[2][31:16]}, 32'ha5c3);
    wr(`SAT_A_CTRL, 32'h0, 2'h0);
    repeat (8) @(posedge aclk);
    chk({28'h0, tbck, tws, tsd, tbck_oe_n}, 32'h1);
    // Master receive clock on, then off
    wr(`SAT_A_CTRL, 32'h200, 2'h0);
    repeat (2) @(posedge aclk);
    chk({31'h0, rbck_oe_n}, 32'h0);
    b0 = rbck;
    repeat (1) @(posedge aclk);
    chk({31'h0, rbck}, {31'h0, ~b0});
    wr(`SAT_A_CTRL, 32'h0, 2'h0);
    repeat (4) @(posedge aclk);
    chk({30'h0, rbck_oe_n, rbck}, 32'h2);
    // Slave receive from the far-side master
    wr(`SAT_A_CTRL, 32'h28, 2'h0);
    wr(`SAT_A_CTRL, 32'h20, 2'h0);
    cstart <= 1'b1;
    @(posedge aclk);
    cstart <= 1'b0;
    @(posedge aclk);
    n = 0;
    while (cbusy && n < 1000)
    begin
      @(posedge aclk);
      n++;
    end
    tmo(n, 1000);
    repeat (4) @(posedge aclk);
    rd(`SAT_A_RXDATA, 32'h9a3c_61e7, 2'h0);
    // DMA receive path, with the transmitter slaved to the far-side clock
    wr(`SAT_A_FCFG, 32'h1000, 2'h0);
    wr(`SAT_A_CTRL, 32'h130, 2'h0);
    repeat (80) @(posedge aclk);
    chk({31'h0, tws}, 32'h0);
    cstart <= 1'b1;
    b0 = 1'b0;
    n = 0;
    do
    begin
      @(posedge aclk);
      cstart <= 1'b0;
      n++;
      b0 = b0 | tws;
    end while (!drx_valid && n < 1200);
    tmo(n, 1200);
    chk({31'h0, b0}, 32'h1);
    chk(drx_data, 32'h9a3c_61e7);
    wrap_up();
  end
endmodule

// ===== src/sat_core.sv
// Function
// (RL1) Separate transmit and receive three-wire units
// (RL2) Clock and data outputs halt when stopped
// (RL3) Each direction has 128x32 FIFO
// (RL4) Control bits 0-3 reset units and FIFOs
// (RL5) Control bit 8 starts master transmit
// (RL6) First frame zero; never written means zero
// (RL7) Underflow repeats the last sent samples
// (RL8) Slave transmit runs on receive-side clock
// (RL9) Control bit 9 drives receive bit clock
// (RL10) Clearing bit 9 stops receive clock
// (RL11) Slave receiver always accepts external data
// (RL12) Bit 12 selects DMA or software FIFO access
// (RL13) FIFO access bit resets to DMA
// (RL14) Transmit packing field bits 13-15; 6,7 invalid
// (RL15) Packing 0 dual 16-bit, 1 single 16-bit
// (RL16) Packing 2,3 put 24-bit sample per word
// (RL17) Packing 4,5 pack 24-bit samples back-to-back
// (RL18) Receive packing bits 16-18, codes 0-3 only
// (RL19) Channel config bits 0-2 hold transmit mode
// (RL20) Transmit modes dual, duplicate, or constant slot
// (RL21) Receive mode bits 3-4: dual, right, left
// (RL22) Control holds prescaler and bit-clock divider
// (RL23) Held FIFO reset empties FIFO and pointers
// (RL24) In DMA mode software FIFO access ignored
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`include "sat_map.svh"
module sat_core
  import sat_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // DMA engine transmit stream
  input wire logic dma_tx_valid,
  input wire logic [31:0] dma_tx_data,
  output logic dma_tx_ready,
  // DMA engine receive stream
  output logic dma_rx_valid,
  output logic [31:0] dma_rx_data,
  input wire logic dma_rx_ready,
  // Transmit link
  output logic tx_bck_out,
  output logic tx_bck_oe_n,
  output logic tx_ws_out,
  output logic tx_sd_out,
  // Receive link
  input wire logic rx_bck_in,
  output logic rx_bck_out,
  output logic rx_bck_oe_n,
  input wire logic rx_ws_in,
  input wire logic rx_sd_in
);
  ////////////////////////////////////////////////////////////////////////////
  // Decode helper shared by read and write paths, and the byte-lane merge used by writes
  function automatic logic sat_known(input logic [7:0] a);
    sat_known = (a <= `SAT_A_CONST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [31:0] sat_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
    sat_merge = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        sat_merge[i*8 +: 8] = nw[i*8 +: 8];
  endfunction

  logic [31:0] ctrl, fcfg, chan, cval;
  logic aw_ok, w_ok;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] wbe;
  logic wr_fire;
  logic dma_sel;
  logic [7:0] tx_count, rx_count;
  logic tx_full, tx_empty, rx_full, rx_empty;
  logic [31:0] tx_head, rx_head, tx_wdata, rx_word;
  logic tx_push, tx_pop, rx_push, rx_pop, sw_rx_pop, dma_rx_pop;
  logic rx_ovr;

  assign wr_fire = aw_ok && w_ok && !bvalid;
  assign dma_sel = fcfg[`SAT_F_DMA]; // RL12

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `SAT_RESP_OK;
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        wa <= awaddr;
        aw_ok <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wd <= wdata;
        wbe <= wstrb;
        w_ok <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp <= sat_known(wa) ? `SAT_RESP_OK : `SAT_RESP_ERR;
        aw_ok <= 1'b0;
        w_ok <= 1'b0;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn) // AXI4-Lite register port
    wr_fire |=> bvalid ##0 (!awready && !wready))
    else $error("write response not raised after address and data");

  // Configuration registers; the FIFO access bit comes up on DMA
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= `SAT_CTRL_RST; // RL4
      fcfg <= `SAT_FCFG_RST; // RL13
      chan <= `SAT_CHAN_RST;
      cval <= `SAT_CONST_RST;
    end
    else if (wr_fire)
    begin
      case (wa)
        `SAT_A_CTRL: ctrl <= sat_merge(ctrl, wd, wbe); // RL22
        `SAT_A_FCFG: fcfg <= sat_merge(fcfg, wd, wbe); // RL14 RL18
        `SAT_A_CHAN: chan <= sat_merge(chan, wd, wbe); // RL19 RL21
        `SAT_A_CONST: cval <= sat_merge(cval, wd, wbe);
        default: ;
      endcase
    end
  end

  a_dma_default: assert property (@(posedge aclk) // RL13
    $rose(aresetn) |-> fcfg[`SAT_F_DMA])
    else $error("FIFO access bit not on DMA after reset");

  ////////////////////////////////////////////////////////////////////////////
  // Read channel; reading the receive data word pops it in software mode
  assign sw_rx_pop = arvalid && arready && (araddr == `SAT_A_RXDATA) && !dma_sel && !rx_empty;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `SAT_RESP_OK;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= sat_known(araddr) ? `SAT_RESP_OK : `SAT_RESP_ERR;
      case (araddr)
        `SAT_A_CTRL: rdata <= ctrl;
        `SAT_A_FCFG: rdata <= fcfg;
        `SAT_A_CHAN: rdata <= chan;
        `SAT_A_CONST: rdata <= cval;
        `SAT_A_RXDATA: rdata <= sw_rx_pop ? rx_head : 32'h0000_0000; // RL24
        `SAT_A_STAT: rdata <= {15'h0000, rx_ovr, rx_count, tx_count};
        default: rdata <= 32'h0000_0000;
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFOs, serviced by software or by the DMA engine
  assign tx_push = dma_sel ? (dma_tx_valid && dma_tx_ready)
                           : (wr_fire && wa == `SAT_A_TXDATA); // RL24
  assign tx_wdata = dma_sel ? dma_tx_data : wd;
  assign dma_rx_pop = dma_sel && !dma_rx_valid && !rx_empty && !ctrl[`SAT_C_RXFRST];
  assign rx_pop = sw_rx_pop || dma_rx_pop;

  sat_fifo u_tx_fifo (
    .aclk(aclk), .aresetn(aresetn), .clr(ctrl[`SAT_C_TXFRST]), // RL3 RL4
    .push(tx_push), .wdata(tx_wdata), .pop(tx_pop), .rdata(tx_head),
    .count(tx_count), .full(tx_full), .empty(tx_empty)
  );

  sat_fifo u_rx_fifo (
    .aclk(aclk), .aresetn(aresetn), .clr(ctrl[`SAT_C_RXFRST]), // RL3 RL4
    .push(rx_push), .wdata(rx_word), .pop(rx_pop), .rdata(rx_head),
    .count(rx_count), .full(rx_full), .empty(rx_empty)
  );

  a_fifo_flush: assert property (@(posedge aclk) disable iff (!aresetn) // RL23
    ctrl[`SAT_C_TXFRST] |=> (tx_count == 8'h00) && tx_empty)
    else $error("transmit FIFO not empty under its reset");

  a_sw_ignored: assert property (@(posedge aclk) disable iff (!aresetn) // RL24
    (wr_fire && wa == `SAT_A_TXDATA && dma_sel && !dma_tx_valid && !tx_pop && !ctrl[`SAT_C_TXFRST])
      |=> tx_count == $past(tx_count))
    else $error("software write reached FIFO in DMA mode");

  // Ready lags the level by a cycle, so two words of room are kept back
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dma_tx_ready <= 1'b0;
    else
      dma_tx_ready <= dma_sel && !ctrl[`SAT_C_TXFRST] && (tx_count < `SAT_DMA_ROOM);
  end

  // Receive words handed to the DMA engine from a holding register
  always_ff @(posedge aclk)
  begin
    if (!aresetn || ctrl[`SAT_C_RXFRST])
      dma_rx_valid <= 1'b0;
    else if (dma_rx_valid && dma_rx_ready)
      dma_rx_valid <= 1'b0;
    else if (dma_rx_pop)
    begin
      dma_rx_valid <= 1'b1;
      dma_rx_data <= rx_head;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and bit-clock divider shared by both master ends
  logic [5:0] pcnt, bcnt;
  logic ce, bck, gen_rise, gen_fall;

  assign gen_fall = ce && (bcnt >= ctrl[`SAT_C_BCK]) && bck;
  assign gen_rise = ce && (bcnt >= ctrl[`SAT_C_BCK]) && !bck;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pcnt <= 6'h00;
      ce <= 1'b0;
    end
    else if (pcnt >= ctrl[`SAT_C_PRE]) // RL22
    begin
      pcnt <= 6'h00;
      ce <= 1'b1;
    end
    else
    begin
      pcnt <= pcnt + 6'h01;
      ce <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bcnt <= 6'h00;
      bck <= 1'b0;
    end
    else if (ce)
    begin
      if (bcnt >= ctrl[`SAT_C_BCK]) // RL22
      begin
        bcnt <= 6'h00;
        bck <= ~bck;
      end
      else
        bcnt <= bcnt + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive clock: shared divider as master, pin as slave
  logic rx_slv, rx_go, rx_en, rx_pin_q, rx_rise, rx_fall;

  assign rx_slv = ctrl[`SAT_C_RXSLV];
  assign rx_go = ctrl[`SAT_C_RXGO] && !ctrl[`SAT_C_RXRST];
  assign rx_en = !ctrl[`SAT_C_RXRST] && (rx_slv || ctrl[`SAT_C_RXGO]) // RL11
                 && (fcfg[`SAT_F_RXPK] < `SAT_RXPK_BAD); // RL18
  assign rx_rise = rx_slv ? (rx_bck_in && !rx_pin_q) : (gen_rise && rx_go);
  assign rx_fall = rx_slv ? (!rx_bck_in && rx_pin_q) : (gen_fall && rx_go);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_pin_q <= 1'b0;
      rx_bck_out <= 1'b0;
      rx_bck_oe_n <= 1'b1;
    end
    else
    begin
      rx_pin_q <= rx_bck_in;
      rx_bck_out <= rx_go && !rx_slv && bck; // RL9 RL10
      rx_bck_oe_n <= !(ctrl[`SAT_C_RXGO] && !rx_slv); // RL9
    end
  end

  a_rx_drive: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
    (ctrl[`SAT_C_RXGO] && !rx_slv) |=> !rx_bck_oe_n)
    else $error("receive master not driving its bit clock");

  a_rx_clk_stop: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
    !ctrl[`SAT_C_RXGO] [*2] |-> !rx_bck_out)
    else $error("receive bit clock runs with start bit clear");

  // Receiver: a select change closes the slot just shifted in
  logic [31:0] rsh;
  logic [15:0] rl16;
  logic rws_q, rdone, rkeep;
  logic [2:0] rpk;
  sat_rxch_t rch;

  assign rpk = fcfg[`SAT_F_RXPK];
  assign rch = sat_rxch_t'(chan[`SAT_H_RXCH]);
  assign rdone = rx_en && rx_rise && (rx_ws_in != rws_q);
  // Codes 1 and 3 with a dual channel setting keep only the left slot
  always_comb
  begin
    case (rch) // RL21
      sat_rxch_right: rkeep = rws_q;
      sat_rxch_left: rkeep = !rws_q;
      default: rkeep = !rpk[0] || !rws_q;
    endcase
  end
  // Codes 0 pairs left and right; 1 half word; 2 and 3 a padded word
  assign rx_push = rdone && rkeep && (rpk[1] || rpk[0] || rws_q);
  assign rx_word = rpk[1] ? {8'h00, rsh[31:8]}
                 : (rpk[0] ? {rsh[31:16], 16'h0000} : {rl16, rsh[31:16]}); // RL18

  always_ff @(posedge aclk)
  begin
    if (!aresetn || ctrl[`SAT_C_RXRST])
    begin
      rsh <= 32'h0000_0000;
      rl16 <= 16'h0000;
      rws_q <= 1'b0;
    end
    else if (rx_en && rx_rise)
    begin
      rsh <= {rsh[30:0], rx_sd_in}; // RL11
      rws_q <= rx_ws_in;
      if (rdone && !rws_q)
        rl16 <= rsh[31:16];
    end
  end

  // Overrun is sticky; a new loss wins over the FIFO reset that clears it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_ovr <= 1'b0;
    else if (rx_push && rx_full)
      rx_ovr <= 1'b1;
    else if (ctrl[`SAT_C_RXFRST])
      rx_ovr <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: 64-bit reservoir unpacks FIFO words into samples
  logic tx_slv, tx_go, tx_run, tx_adv, started, zf, single, sw16, got, take, fill;
  logic [2:0] tpk;
  logic [5:0] tbit;
  logic [31:0] tslot, uword;
  logic [63:0] res, r1;
  logic [6:0] rcnt, c1, ulen, nd;
  logic [23:0] s1, s2, a_l, b_r, fl, fr, last_l, last_r;
  sat_txch_t tch;

  assign tx_slv = ctrl[`SAT_C_TXSLV];
  assign tpk = fcfg[`SAT_F_TXPK];
  assign tch = sat_txch_t'(chan[`SAT_H_TXCH]); // RL19
  assign tx_go = ctrl[`SAT_C_TXGO] && !ctrl[`SAT_C_TXRST];
  assign tx_run = tx_go && (tpk < `SAT_TXPK_BAD); // RL14
  assign tx_adv = tx_run && (tx_slv ? rx_fall : gen_fall); // RL8
  assign single = tpk[0];
  assign sw16 = tpk < 3'h2;
  assign nd = single ? (sw16 ? `SAT_W16 : `SAT_W24) : (sw16 ? `SAT_W32 : 7'(2 * `SAT_W24));
  assign got = rcnt >= nd;
  assign take = tx_adv && (tbit == `SAT_FRAME_LAST) && started && got;
  assign s1 = sw16 ? {res[63:48], 8'h00} : res[63:40];
  assign s2 = sw16 ? {res[47:32], 8'h00} : res[39:16];
  assign a_l = got ? s1 : last_l; // RL7
  assign b_r = got ? (single ? s1 : s2) : last_r; // RL7

  // Useful bits of one FIFO word, left aligned
  always_comb
  begin
    case (tpk)
      3'h0: begin uword = tx_head; ulen = `SAT_W32; end // RL15
      3'h1: begin uword = {tx_head[31:16], 16'h0000}; ulen = `SAT_W16; end // RL15
      3'h2, 3'h3: begin uword = {tx_head[23:0], 8'h00}; ulen = `SAT_W24; end // RL16
      default: begin uword = tx_head; ulen = `SAT_W32; end // RL17
    endcase
  end

  // Take a frame's samples, then top up from the FIFO in the same cycle
  always_comb
  begin
    r1 = take ? (res << nd) : res;
    c1 = take ? (rcnt - nd) : rcnt;
    fill = tx_run && !tx_empty && ((c1 + ulen) <= `SAT_RES_BITS);
  end
  assign tx_pop = fill;

  // Channel mode picks what each slot carries
  always_comb
  begin
    case (tch) // RL20
      sat_txch_rdup: begin fl = b_r; fr = b_r; end
      sat_txch_ldup: begin fl = a_l; fr = a_l; end
      sat_txch_rconst: begin fl = cval[23:0]; fr = b_r; end
      sat_txch_lconst: begin fl = a_l; fr = cval[23:0]; end
      default: begin fl = a_l; fr = b_r; end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || ctrl[`SAT_C_TXRST])
    begin
      res <= 64'h0;
      rcnt <= 7'h00;
    end
    else
    begin
      res <= fill ? (r1 | ({uword, 32'h0000_0000} >> c1)) : r1; // RL17
      rcnt <= fill ? (c1 + ulen) : c1;
    end
  end

  // Frame sequencer; the first frame after a start is all zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tx_run)
    begin
      tbit <= `SAT_FRAME_LAST;
      tslot <= 32'h0000_0000;
      started <= 1'b0;
      zf <= 1'b1;
      if (!aresetn || ctrl[`SAT_C_TXRST])
      begin
        last_l <= 24'h000000; // RL6
        last_r <= 24'h000000;
      end
    end
    else if (tx_adv)
    begin
      tbit <= tbit + 6'h01;
      if (tbit == `SAT_FRAME_LAST)
      begin
        started <= 1'b1;
        zf <= !started;
        tslot <= started ? {fl, 8'h00} : 32'h0000_0000; // RL6
        if (started)
        begin
          last_l <= a_l;
          last_r <= b_r;
        end
      end
      else if (tbit[4:0] == `SAT_SLOT_LAST)
        tslot <= zf ? 32'h0000_0000 : {fr, 8'h00};
      else
        tslot <= {tslot[30:0], 1'b0};
    end
  end

  // Pins: stopped transmitter holds clock and data low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_bck_out <= 1'b0;
      tx_bck_oe_n <= 1'b1;
      tx_ws_out <= 1'b0;
      tx_sd_out <= 1'b0;
    end
    else
    begin
      tx_bck_out <= tx_run && !tx_slv && bck; // RL2 RL5
      tx_bck_oe_n <= !(ctrl[`SAT_C_TXGO] && !tx_slv); // RL5 RL1
      tx_ws_out <= tx_run && started && tbit[5]; // No right-slot flash before the first frame
      tx_sd_out <= tx_run && tslot[31]; // RL2
    end
  end

  a_tx_halt: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
    !ctrl[`SAT_C_TXGO] |=> (!tx_bck_out && !tx_sd_out && !tx_ws_out))
    else $error("transmit pins active while stopped");

  a_tx_master: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
    (ctrl[`SAT_C_TXGO] && !tx_slv) |=> !tx_bck_oe_n)
    else $error("transmit master not driving its bit clock");

  a_first_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
    (tx_run && zf && $past(zf) && $past(tx_run)) |-> !tx_sd_out)
    else $error("first transmit frame not zero");
endmodule

// ===== src/sat_fifo.sv
`include "sat_map.svh"
module sat_fifo
  import sat_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Flush
  input wire logic clr,
  // Write side
  input wire logic push,
  input wire logic [31:0] wdata,
  // Read side
  input wire logic pop,
  output logic [31:0] rdata,
  // Level
  output logic [7:0] count,
  output logic full,
  output logic empty
);
  logic [31:0] mem [0:`SAT_FIFO_DEPTH-1];
  logic [`SAT_FIFO_AW-1:0] wptr;
  logic [`SAT_FIFO_AW-1:0] rptr;
  logic do_push;
  logic do_pop;

  // Pushes into a full FIFO and pops from an empty one are dropped
  assign full = count == 8'(`SAT_FIFO_DEPTH);
  assign empty = count == 8'h00;
  assign do_push = push && !full && !clr;
  assign do_pop = pop && !empty && !clr;
  assign rdata = mem[rptr];

  // Storage
  always_ff @(posedge aclk)
  begin
    if (do_push)
      mem[wptr] <= wdata;
  end

  // Pointers stay at home while the flush bit is held
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clr)
    begin
      wptr <= '0; // RL23
      rptr <= '0;
      count <= 8'h00;
    end
    else
    begin
      if (do_push)
        wptr <= wptr + 1'b1;
      if (do_pop)
        rptr <= rptr + 1'b1;
      count <= count + 8'(do_push) - 8'(do_pop);
    end
  end
endmodule

// ===== src/sat_map.svh
`ifndef SAT_MAP_SVH
`define SAT_MAP_SVH
// Register byte offsets
`define SAT_A_CTRL 8'h00
`define SAT_A_FCFG 8'h04
`define SAT_A_CHAN 8'h08
`define SAT_A_TXDATA 8'h0c
`define SAT_A_RXDATA 8'h10
`define SAT_A_STAT 8'h14
`define SAT_A_CONST 8'h18
// Reset values
`define SAT_CTRL_RST 32'h0000_0000
`define SAT_FCFG_RST 32'h0000_1000
`define SAT_CHAN_RST 32'h0000_0000
`define SAT_CONST_RST 32'h0000_0000
// Control register fields
`define SAT_C_TXRST 0
`define SAT_C_RXRST 1
`define SAT_C_TXFRST 2
`define SAT_C_RXFRST 3
`define SAT_C_TXSLV 4
`define SAT_C_RXSLV 5
`define SAT_C_TXGO 8
`define SAT_C_RXGO 9
`define SAT_C_PRE 21:16
`define SAT_C_BCK 27:22
// FIFO and channel configuration fields
`define SAT_F_DMA 12
`define SAT_F_TXPK 15:13
`define SAT_F_RXPK 18:16
`define SAT_H_TXCH 2:0
`define SAT_H_RXCH 4:3
// Status fields
`define SAT_S_TXCNT 7:0
`define SAT_S_RXCNT 15:8
`define SAT_S_OVR 16
// First invalid packing codes
`define SAT_TXPK_BAD 3'h6
`define SAT_RXPK_BAD 3'h4
// FIFO shape
`define SAT_FIFO_DEPTH 128
`define SAT_FIFO_AW 7
`define SAT_DMA_ROOM 8'h7e
// Frame timing and sample widths
`define SAT_SLOT_LAST 5'h1f
`define SAT_FRAME_LAST 6'h3f
`define SAT_RES_BITS 7'h40
`define SAT_W16 7'h10
`define SAT_W24 7'h18
`define SAT_W32 7'h20
// Bus responses
`define SAT_RESP_OK 2'h0
`define SAT_RESP_ERR 2'h2
`endif

// ===== src/sat_pkg.sv
package sat_pkg;
  // Transmit channel modes
  typedef enum logic [2:0] {
    sat_txch_dual = 3'b000,
    sat_txch_rdup = 3'b001,
    sat_txch_ldup = 3'b010,
    sat_txch_rconst = 3'b011,
    sat_txch_lconst = 3'b100
  } sat_txch_t;
  // Receive channel modes
  typedef enum logic [1:0] {
    sat_rxch_dual = 2'b00,
    sat_rxch_right = 2'b01,
    sat_rxch_left = 2'b10
  } sat_rxch_t;
endpackage
